// ### pkg/ddc_config_defines.vh
// Constants for the downconverter unit one configuration bank
// Notes on behaviour
// - Complex-to-real 0 gives I and Q; 1 gives real I only via fs mixing.
// - Basic code 000: halfband one and two, ratio 2 real or 4 complex.
// - Basic code 001: halfband one to three, ratio 4 real or 8 complex.
// - Basic code 010: halfband one to four, ratio 8 real or 16 complex.
// - Basic code 011: halfband one only, ratio 1 real or 2 complex.
// - Basic code 100: halfband one plus thirdband second, ratio 3 or 6.
// - Basic code 101: halfband one, two, thirdband second, ratio 6 or 12.
// - Basic code 110: halfband one to three, thirdband second, 12 or 24.
// - Basic code 111 hands selection to extended nibble of input select.
// - Extended 0: thirdband second plus halfband four..one, 48 or 24.
// - Extended 2: fifthband second plus halfband one, 10 or 5.
// - Extended 3: fifthband second plus halfband two and one, 20 or 10.
// - Extended 4: fifthband second plus halfband three..one, 40 or 20.
// - Extended 7: thirdband first only, ratio 3; real output unsupported.
// - Extended 8: fifthband second plus thirdband first, 15; no real.
// - Extended 9: halfband two, fifthband second, thirdband first, 30.
// - NCO mode 0 takes channel from register-based select field.
// - NCO modes 1 to 6 build channel from side pin levels.
// - NCO modes 8 to 11 count rising edges of one side pin.
// - Edge counter counts up to the NCO control low nibble, then wraps to 0 on the next edge.
`ifndef DDC_CONFIG_DEFINES_VH
`define DDC_CONFIG_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_NCO_MAP_SELECT   12'h314
`define IDX_CONTROL          12'h330
`define IDX_INPUT_SELECT     12'h331
`define IDX_NCO_CONTROL      12'h334

`define RST_NCO_MAP_SELECT   8'h00
`define RST_CONTROL          8'h00
`define RST_INPUT_SELECT     8'h05
`define RST_NCO_CONTROL      8'h00

// Writable bit masks; clear bits are reserved
`define MASK_NCO_MAP_SELECT  8'h0F
`define MASK_CONTROL         8'hFF
`define MASK_INPUT_SELECT    8'hF5
`define MASK_NCO_CONTROL     8'hFF

// Control register fields
`define BIT_MIXER            7
`define BIT_GAIN             6
`define BIT_C2R              3

// Input select fields
`define BIT_Q_SEL            2
`define BIT_I_SEL            0

// Field positions
`define FLD_ADDR_INDEX       13:2
`define FLD_DEC              2:0
`define FLD_IF_MODE          5:4
`define FLD_EXT              7:4
`define FLD_MODE             7:4
`define FLD_EDGE_PIN         5:4
`define FLD_WRAP             3:0
`define FLD_MAP              3:0

// H, T, F: halfband, thirdband and fifthband stages
// Basic decimation codes
`define DEC_H12              3'h0
`define DEC_H123             3'h1
`define DEC_H1234            3'h2
`define DEC_H1               3'h3
`define DEC_H1_T2            3'h4
`define DEC_H12_T2           3'h5
`define DEC_H123_T2          3'h6
`define DEC_EXTENDED         3'h7

// Extended decimation codes
`define EXT_T2_H4321         4'h0
`define EXT_F2_H1            4'h2
`define EXT_F2_H21           4'h3
`define EXT_F2_H321          4'h4
`define EXT_T1               4'h7
`define EXT_F2_T1            4'h8
`define EXT_H2_F2_T1         4'h9

// Complex-output ratios; real output halves them, except 3, 15 and 30
`define RATIO_W              6
`define RATIO_2              6'h02
`define RATIO_3              6'h03
`define RATIO_4              6'h04
`define RATIO_8              6'h08
`define RATIO_10             6'h0A
`define RATIO_6              6'h06
`define RATIO_12             6'h0C
`define RATIO_15             6'h0F
`define RATIO_16             6'h10
`define RATIO_20             6'h14
`define RATIO_24             6'h18
`define RATIO_30             6'h1E
`define RATIO_40             6'h28
`define RATIO_48             6'h30

// Stage enable vector bit order
`define STG_H1               0
`define STG_H2               1
`define STG_H3               2
`define STG_H4               3
`define STG_T1               4
`define STG_T2               5
`define STG_F2               6

// NCO channel select modes
`define NCO_REG              4'h0
`define NCO_B0A0             4'h1
`define NCO_B1A1             4'h2
`define NCO_A1A0             4'h3
`define NCO_B1B0             4'h4
`define NCO_B1A1B0A0         4'h5
`define NCO_B1B0A1A0         4'h6
`define NCO_EDGE_A0          4'h8
`define NCO_EDGE_A1          4'h9
`define NCO_EDGE_B0          4'hA
`define NCO_EDGE_B1          4'hB

`endif

// ### design/ddc_config.v
// Configuration bank for downconverter unit one with Avalon-MM access
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "ddc_config_defines.vh"

module ddc_config (
    input  wire        i_ref_clk,
    input  wire        i_arst_n,
    input  wire [13:0] i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    input  wire [3:0]  i_avs_byteenable,
    input  wire        i_side_a_pin_zero,
    input  wire        i_side_a_pin_one,
    input  wire        i_side_b_pin_zero,
    input  wire        i_side_b_pin_one,
    output reg  [31:0] o_avs_readdata,
    output reg         o_avs_waitrequest,
    output reg         o_real_only,
    output reg         o_complex_mixer,
    output reg         o_gain_6db,
    output reg  [1:0]  o_if_mode,
    output reg         o_halfband_stage_one_en,
    output reg         o_halfband_stage_two_en,
    output reg         o_halfband_stage_three_en,
    output reg         o_halfband_stage_four_en,
    output reg         o_thirdband_stage_first_en,
    output reg         o_thirdband_stage_second_en,
    output reg         o_fifthband_stage_second_en,
    output reg  [5:0]  o_decim_ratio,
    output reg         o_decim_valid,
    output reg         o_i_from_channel_b,
    output reg         o_q_from_channel_b,
    output reg  [3:0]  o_nco_channel
);

    reg  [7:0] nco_map_select;
    reg  [7:0] control;
    reg  [7:0] input_select;
    reg  [7:0] nco_control;
    reg  [3:0] edge_count;
    reg  [3:0] pins_prev;

    wire [3:0] pins;
    wire [3:0] pin_rise;
    wire [11:0] index;
    wire       take;
    wire       wr_take;

    reg  [7:0] next_rdata;
    reg  [6:0] next_stages;
    reg  [5:0] next_base;
    reg        next_defined;
    reg        next_no_half;
    reg  [3:0] next_channel;
    reg        next_count_en;
    reg        sel_rise;

    // Pin vector order: A0, A1, B0, B1
    assign pins = {i_side_b_pin_one, i_side_b_pin_zero,
                   i_side_a_pin_one, i_side_a_pin_zero};
    assign pin_rise = pins & ~pins_prev;
    assign index = i_avs_address[`FLD_ADDR_INDEX];

    // One wait cycle per access, then accept at the edge wait is low
    assign take = (i_avs_read | i_avs_write) & ~o_avs_waitrequest;
    assign wr_take = take & i_avs_write & i_avs_byteenable[0];

    // Read mux; unmapped addresses read zero
    always @* begin
        case (index)
            `IDX_NCO_MAP_SELECT:
                next_rdata = nco_map_select & `MASK_NCO_MAP_SELECT;
            `IDX_CONTROL:
                next_rdata = control;
            `IDX_INPUT_SELECT:
                next_rdata = input_select & `MASK_INPUT_SELECT;
            `IDX_NCO_CONTROL:
                next_rdata = nco_control;
            default:
                next_rdata = 8'h00;
        endcase
    end

    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0000_0000;
        end else begin
            if ((i_avs_read | i_avs_write) & o_avs_waitrequest) begin
                o_avs_waitrequest <= 1'b0;
                o_avs_readdata    <= {24'h00_0000, next_rdata};
            end else begin
                o_avs_waitrequest <= 1'b1;
            end
        end
    end

    // Register writes; reserved bits are masked on entry
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            nco_map_select <= `RST_NCO_MAP_SELECT;
            control        <= `RST_CONTROL;
            input_select   <= `RST_INPUT_SELECT;
            nco_control    <= `RST_NCO_CONTROL;
        end else if (wr_take) begin
            case (index)
                `IDX_NCO_MAP_SELECT:
                    nco_map_select <= i_avs_writedata[7:0]
                                      & `MASK_NCO_MAP_SELECT;
                `IDX_CONTROL:
                    control <= i_avs_writedata[7:0] & `MASK_CONTROL;
                `IDX_INPUT_SELECT:
                    input_select <= i_avs_writedata[7:0]
                                    & `MASK_INPUT_SELECT;
                `IDX_NCO_CONTROL:
                    nco_control <= i_avs_writedata[7:0] & `MASK_NCO_CONTROL;
                default: begin
                end
            endcase
        end
    end

    // Filter chain and ratio decode
    always @* begin
        next_stages  = 7'h00;
        next_base    = `RATIO_2;
        next_defined = 1'b1;
        next_no_half = 1'b0;
        case (control[`FLD_DEC])
            `DEC_H12: begin
                next_stages[`STG_H1] = 1'b1;
                next_stages[`STG_H2] = 1'b1;
                next_base = `RATIO_4;
            end
            `DEC_H123: begin
                next_stages[`STG_H3:`STG_H1] = 3'h7;
                next_base = `RATIO_8;
            end
            `DEC_H1234: begin
                next_stages[`STG_H4:`STG_H1] = 4'hF;
                next_base = `RATIO_16;
            end
            `DEC_H1: begin
                next_stages[`STG_H1] = 1'b1;
                next_base = `RATIO_2;
            end
            `DEC_H1_T2: begin
                next_stages[`STG_H1] = 1'b1;
                next_stages[`STG_T2] = 1'b1;
                next_base = `RATIO_6;
            end
            `DEC_H12_T2: begin
                next_stages[`STG_H2:`STG_H1] = 2'h3;
                next_stages[`STG_T2] = 1'b1;
                next_base = `RATIO_12;
            end
            `DEC_H123_T2: begin
                next_stages[`STG_H3:`STG_H1] = 3'h7;
                next_stages[`STG_T2] = 1'b1;
                next_base = `RATIO_24;
            end
            default: begin
                // Extended nibble applies only under basic code 111
                case (input_select[`FLD_EXT])
                    `EXT_T2_H4321: begin
                        next_stages[`STG_H4:`STG_H1] = 4'hF;
                        next_stages[`STG_T2] = 1'b1;
                        next_base = `RATIO_48;
                    end
                    `EXT_F2_H1: begin
                        next_stages[`STG_F2] = 1'b1;
                        next_stages[`STG_H1] = 1'b1;
                        next_base = `RATIO_10;
                    end
                    `EXT_F2_H21: begin
                        next_stages[`STG_F2] = 1'b1;
                        next_stages[`STG_H2:`STG_H1] = 2'h3;
                        next_base = `RATIO_20;
                    end
                    `EXT_F2_H321: begin
                        next_stages[`STG_F2] = 1'b1;
                        next_stages[`STG_H3:`STG_H1] = 3'h7;
                        next_base = `RATIO_40;
                    end
                    `EXT_T1: begin
                        next_stages[`STG_T1] = 1'b1;
                        next_base = `RATIO_3;
                        next_no_half = 1'b1;
                    end
                    `EXT_F2_T1: begin
                        next_stages[`STG_F2] = 1'b1;
                        next_stages[`STG_T1] = 1'b1;
                        next_base = `RATIO_15;
                        next_no_half = 1'b1;
                    end
                    `EXT_H2_F2_T1: begin
                        next_stages[`STG_H2] = 1'b1;
                        next_stages[`STG_F2] = 1'b1;
                        next_stages[`STG_T1] = 1'b1;
                        next_base = `RATIO_30;
                        next_no_half = 1'b1;
                    end
                    default: begin
                        // Undefined codes leave every stage off
                        next_defined = 1'b0;
                        next_base = 6'h00;
                    end
                endcase
            end
        endcase
    end

    // NCO channel source selection
    always @* begin
        next_count_en = 1'b0;
        sel_rise = 1'b0;
        case (nco_control[`FLD_MODE])
            `NCO_REG:
                next_channel = nco_map_select[`FLD_MAP];
            `NCO_B0A0:
                next_channel = {2'b00, pins[2], pins[0]};
            `NCO_B1A1:
                next_channel = {2'b00, pins[3], pins[1]};
            `NCO_A1A0:
                next_channel = {2'b00, pins[1], pins[0]};
            `NCO_B1B0:
                next_channel = {2'b00, pins[3], pins[2]};
            `NCO_B1A1B0A0:
                next_channel = {pins[3], pins[1], pins[2], pins[0]};
            `NCO_B1B0A1A0:
                next_channel = {pins[3], pins[2], pins[1], pins[0]};
            `NCO_EDGE_A0, `NCO_EDGE_A1, `NCO_EDGE_B0, `NCO_EDGE_B1: begin
                next_count_en = 1'b1;
                sel_rise = pin_rise[nco_control[`FLD_EDGE_PIN]];
                next_channel = edge_count;
            end
            default:
                next_channel = 4'h0;
        endcase
    end

    // Edge counter; wraps past the limit so a lowered limit recovers
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pins_prev  <= 4'h0;
            edge_count <= 4'h0;
        end else begin
            pins_prev <= pins;
            if (next_count_en && sel_rise) begin
                if (edge_count >= nco_control[`FLD_WRAP])
                    edge_count <= 4'h0;
                else
                    edge_count <= edge_count + 4'h1;
            end
        end
    end

    // Registered outputs
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_real_only                 <= 1'b0;
            o_complex_mixer             <= 1'b0;
            o_gain_6db                  <= 1'b0;
            o_if_mode                   <= 2'b00;
            o_halfband_stage_one_en     <= 1'b0;
            o_halfband_stage_two_en     <= 1'b0;
            o_halfband_stage_three_en   <= 1'b0;
            o_halfband_stage_four_en    <= 1'b0;
            o_thirdband_stage_first_en  <= 1'b0;
            o_thirdband_stage_second_en <= 1'b0;
            o_fifthband_stage_second_en <= 1'b0;
            o_decim_ratio               <= 6'h00;
            o_decim_valid               <= 1'b0;
            o_i_from_channel_b          <= 1'b1;
            o_q_from_channel_b          <= 1'b1;
            o_nco_channel               <= 4'h0;
        end else begin
            o_real_only     <= control[`BIT_C2R];
            o_complex_mixer <= control[`BIT_MIXER];
            o_gain_6db      <= control[`BIT_GAIN];
            o_if_mode       <= control[`FLD_IF_MODE];
            o_halfband_stage_one_en     <= next_stages[`STG_H1];
            o_halfband_stage_two_en     <= next_stages[`STG_H2];
            o_halfband_stage_three_en   <= next_stages[`STG_H3];
            o_halfband_stage_four_en    <= next_stages[`STG_H4];
            o_thirdband_stage_first_en  <= next_stages[`STG_T1];
            o_thirdband_stage_second_en <= next_stages[`STG_T2];
            o_fifthband_stage_second_en <= next_stages[`STG_F2];
            // Real output halves the ratio where the chain allows it
            if (control[`BIT_C2R] && !next_no_half)
                o_decim_ratio <= next_base >> 1;
            else
                o_decim_ratio <= next_base;
            // Halved ratios of 1.5, 7.5 and 15 do not exist
            o_decim_valid <= next_defined
                             & ~(control[`BIT_C2R] & next_no_half);
            o_i_from_channel_b <= input_select[`BIT_I_SEL];
            o_q_from_channel_b <= input_select[`BIT_Q_SEL];
            o_nco_channel <= next_channel;
        end
    end

endmodule
`default_nettype wire

// ### testbench/ddc_config_props.sv
// Port-level assertions for the downconverter configuration bank
`timescale 1ns/1ns
`default_nettype none
`include "ddc_config_defines.vh"
module ddc_config_props (
    input wire logic        i_ref_clk,
    input wire logic        i_arst_n,
    input wire logic [13:0] i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic        i_side_a_pin_zero,
    input wire logic        i_side_a_pin_one,
    input wire logic        i_side_b_pin_zero,
    input wire logic        i_side_b_pin_one,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        o_real_only,
    input wire logic        o_halfband_stage_one_en,
    input wire logic        o_halfband_stage_two_en,
    input wire logic        o_halfband_stage_three_en,
    input wire logic        o_halfband_stage_four_en,
    input wire logic        o_thirdband_stage_first_en,
    input wire logic        o_thirdband_stage_second_en,
    input wire logic        o_fifthband_stage_second_en,
    input wire logic [5:0]  o_decim_ratio,
    input wire logic        o_decim_valid,
    input wire logic        o_i_from_channel_b,
    input wire logic        o_q_from_channel_b,
    input wire logic [3:0]  o_nco_channel
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    wire logic [11:0] idx = i_avs_address[13:2];
    wire logic [7:0]  rd8 = o_avs_readdata[7:0];
    wire logic        acc = !o_avs_waitrequest && (i_avs_read || i_avs_write);
    wire logic        wr0 = acc && i_avs_write && i_avs_byteenable[0];
    wire logic [3:0]  pin = {i_side_b_pin_one, i_side_b_pin_zero,
                             i_side_a_pin_one, i_side_a_pin_zero};
    logic [3:0] mode;
    int         prod;

    // Shadow of the mode field, the register itself is not visible here
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            mode <= 4'h0;
        else if (wr0 && idx == `IDX_NCO_CONTROL)
            mode <= i_avs_writedata[7:4];
    end

    always_comb begin
        prod = (o_halfband_stage_one_en ? 2 : 1) *
               (o_halfband_stage_two_en ? 2 : 1) *
               (o_halfband_stage_three_en ? 2 : 1) *
               (o_halfband_stage_four_en ? 2 : 1) *
               (o_thirdband_stage_first_en ? 3 : 1) *
               (o_thirdband_stage_second_en ? 3 : 1) *
               (o_fifthband_stage_second_en ? 5 : 1);
    end

    function automatic logic [3:0] lvl(input logic [3:0] m,
                                       input logic [3:0] v);
        case (m)
            4'h1: return {2'b00, v[2], v[0]};
            4'h2: return {2'b00, v[3], v[1]};
            4'h3: return {2'b00, v[1:0]};
            4'h4: return {2'b00, v[3:2]};
            4'h5: return {v[3], v[1], v[2], v[0]};
            default: return v;
        endcase
    endfunction

    AST_WAIT_ONE: assert property ($fell(o_avs_waitrequest) |=>
        o_avs_waitrequest) else $error("waitrequest low too long");
    AST_ANSWER: assert property ((i_avs_read || i_avs_write) &&
        o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("request not answered after one cycle");
    AST_IDLE: assert property (!i_avs_read && !i_avs_write |=>
        o_avs_waitrequest) else $error("waitrequest low while idle");
    AST_RD_RSV: assert property (acc && i_avs_read |->
        o_avs_readdata[31:8] == 24'h0 &&
        !(idx == `IDX_INPUT_SELECT && (rd8[3] || rd8[1])) &&
        !(idx == `IDX_NCO_MAP_SELECT && rd8[7:4] != 4'h0) &&
        (idx inside {`IDX_NCO_MAP_SELECT, `IDX_CONTROL, `IDX_INPUT_SELECT,
                     `IDX_NCO_CONTROL} || rd8 == 8'h00))
        else $error("reserved or unmapped bits read nonzero");
    AST_C2R: assert property (wr0 && idx == `IDX_CONTROL |->
        ##2 o_real_only == $past(i_avs_writedata[3], 2))
        else $error("real output flag does not follow write");
    AST_ROUTE: assert property (wr0 && idx == `IDX_INPUT_SELECT |->
        ##2 o_i_from_channel_b == $past(i_avs_writedata[0], 2) &&
        o_q_from_channel_b == $past(i_avs_writedata[2], 2))
        else $error("input routing does not follow write");
    AST_RATIO: assert property (o_decim_valid |->
        int'(o_decim_ratio) == (o_real_only ? prod / 2 : prod))
        else $error("ratio does not match enabled stages");
    AST_TB1_REAL: assert property (o_thirdband_stage_first_en &&
        o_real_only |-> !o_decim_valid)
        else $error("unsupported real ratio flagged valid");
    AST_LEVEL: assert property (mode inside {[1:6]} && $stable(mode) &&
        $stable(pin) && pin == $past(pin, 2) |->
        o_nco_channel == lvl(mode, pin))
        else $error("pin-built channel wrong");
    AST_EDGE_STEP: assert property (mode[3:2] == 2'b10 &&
        mode == $past(mode) && mode == $past(mode, 2) &&
        o_nco_channel != $past(o_nco_channel) |->
        o_nco_channel == $past(o_nco_channel) + 4'h1 ||
        o_nco_channel == 4'h0) else $error("edge counter jumped");
endmodule

bind ddc_config ddc_config_props u_props (.*);
`default_nettype wire

// ### testbench/ddc_config_tb.sv
// Self-checking bench for the downconverter configuration bank
`timescale 1ns/1ns
`default_nettype none
`include "ddc_config_defines.vh"
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin err_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, x); end end
module ddc_config_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [13:0] addr = 14'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'hF;
    logic [3:0]  pins = 4'h0;
    wire  [31:0] rdata;
    wire         waitreq;
    wire         real_only;
    wire  [3:0]  ctl;
    wire  [6:0]  stg;
    wire  [5:0]  ratio;
    wire         valid;
    wire         i_b;
    wire         q_b;
    wire  [3:0]  chan;
    int          err_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [6:0]  stab [14] = '{7'h03, 7'h07, 7'h0F, 7'h01, 7'h21, 7'h23,
        7'h27, 7'h2F, 7'h41, 7'h43, 7'h47, 7'h10, 7'h50, 7'h52};
    logic [5:0]  rtab [14] = '{6'h04, 6'h08, 6'h10, 6'h02, 6'h06, 6'h0C,
        6'h18, 6'h30, 6'h0A, 6'h14, 6'h28, 6'h03, 6'h0F, 6'h1E};
    logic [3:0]  xtab [7] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9};

    ddc_config uut (
        .i_ref_clk(clk),
        .i_arst_n(rst_n),
        .i_avs_address(addr),
        .i_avs_read(rd),
        .i_avs_write(wr),
        .i_avs_writedata(wdata),
        .i_avs_byteenable(be),
        .i_side_a_pin_zero(pins[0]),
        .i_side_a_pin_one(pins[1]),
        .i_side_b_pin_zero(pins[2]),
        .i_side_b_pin_one(pins[3]),
        .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq),
        .o_real_only(real_only),
        .o_complex_mixer(ctl[3]),
        .o_gain_6db(ctl[2]),
        .o_if_mode(ctl[1:0]),
        .o_halfband_stage_one_en(stg[0]),
        .o_halfband_stage_two_en(stg[1]),
        .o_halfband_stage_three_en(stg[2]),
        .o_halfband_stage_four_en(stg[3]),
        .o_thirdband_stage_first_en(stg[4]),
        .o_thirdband_stage_second_en(stg[5]),
        .o_fifthband_stage_second_en(stg[6]),
        .o_decim_ratio(ratio),
        .o_decim_valid(valid),
        .o_i_from_channel_b(i_b),
        .o_q_from_channel_b(q_b),
        .o_nco_channel(chan)
    );

    always #5 clk = ~clk;

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles > 6000) begin
            err_count++;
            report_and_stop;
        end
    end

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [11:0] i,
                       input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        addr <= {i, 2'b00};
        wdata <= {24'h0, d};
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (waitreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wrr(input logic [11:0] i, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, i, d, q);
    endtask

    task automatic rdc(input logic [11:0] i, input logic [7:0] x);
        logic [31:0] q;
        bus(1'b0, i, 8'h00, q);
        `CHK(q, {24'h0, x})
    endtask

    // Outputs trail the register by one clock; three leaves margin
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask

    task automatic pulse(input int b);
        pins <= 4'h1 << b;
        repeat (3) @(posedge clk);
        pins <= 4'h0;
        settle;
    endtask

    function automatic logic [3:0] lvl(input int m, input logic [3:0] v);
        case (m)
            1: return {2'b00, v[2], v[0]};
            2: return {2'b00, v[3], v[1]};
            3: return {2'b00, v[1:0]};
            4: return {2'b00, v[3:2]};
            5: return {v[3], v[1], v[2], v[0]};
            default: return v;
        endcase
    endfunction

    initial begin
        int k, n, c, m, cnt;
        logic [5:0] er;
        logic [3:0] pv;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        settle;
        `CHK({stg, ratio, valid, i_b, q_b}, {7'h03, 6'h04, 3'h7})
        rdc(`IDX_INPUT_SELECT, 8'h05);
        rdc(`IDX_NCO_CONTROL, 8'h00);
        rdc(`IDX_CONTROL, 8'h00);
        rdc(`IDX_NCO_MAP_SELECT, 8'h00);
        wrr(`IDX_INPUT_SELECT, 8'hFF);
        rdc(`IDX_INPUT_SELECT, 8'hF5);
        wrr(`IDX_NCO_MAP_SELECT, 8'hFF);
        rdc(`IDX_NCO_MAP_SELECT, 8'h0F);
        wrr(12'h3FF, 8'hFF);
        rdc(12'h3FF, 8'h00);
        be <= 4'h0;
        wrr(`IDX_CONTROL, 8'hFF);
        be <= 4'hF;
        rdc(`IDX_CONTROL, 8'h00);
        wrr(`IDX_CONTROL, 8'hF0);
        settle;
        `CHK({ctl, real_only}, 5'h1E)
        for (k = 0; k < 2; k++) begin
            wrr(`IDX_INPUT_SELECT, k ? 8'h01 : 8'h04);
            settle;
            `CHK({i_b, q_b}, k ? 2'b10 : 2'b01)
        end
        // Nonzero nibble must be ignored while the basic code is not 111
        wrr(`IDX_INPUT_SELECT, 8'h95);
        for (k = 0; k < 28; k++) begin
            n = k % 14;
            c = k / 14;
            if (n > 6)
                wrr(`IDX_INPUT_SELECT, {xtab[n - 7], 4'h5});
            wrr(`IDX_CONTROL, {4'h0, c[0], n > 6 ? 3'h7 : n[2:0]});
            settle;
            er = (c && n < 11) ? rtab[n] >> 1 : rtab[n];
            `CHK(stg, stab[n])
            `CHK(real_only, c[0])
            `CHK({valid, ratio}, {!(c && n > 10), er})
        end
        wrr(`IDX_NCO_MAP_SELECT, 8'h0B);
        wrr(`IDX_NCO_CONTROL, 8'h00);
        settle;
        `CHK(chan, 4'hB)
        for (k = 0; k < 12; k++) begin
            m = k % 6 + 1;
            pv = k < 6 ? 4'h3 : 4'hC;
            pins <= pv;
            wrr(`IDX_NCO_CONTROL, {m[3:0], 4'h0});
            settle;
            `CHK(chan, lvl(m, pv))
        end
        pins <= 4'h0;
        wrr(`IDX_NCO_CONTROL, 8'h80);
        pulse(0);
        `CHK(chan, 4'h0)
        cnt = 0;
        for (k = 0; k < 16; k++) begin
            m = k / 4;
            wrr(`IDX_NCO_CONTROL, {2'b10, m[1:0], 4'h2});
            pulse(k % 4 == 3 ? (m + 1) % 4 : m);
            if (k % 4 != 3)
                cnt = cnt >= 2 ? 0 : cnt + 1;
            `CHK(chan, cnt[3:0])
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
